// >>> verilog/isxe_exec.sv
// executor for skip, increment, or, jump and pointer-load instructions
//
// Summary of operation
// - destination bit picks accumulator or file register
// - bank bit picks access bank or bank select
// - decrement, skip next when result zero
// - decrement, skip next when result nonzero
// - increment, skip next when result zero
// - increment, skip next when result nonzero
// - skip costs one idle, two over two-word
// - increment updates carry, digit, negative, overflow, zero
// - or literal into accumulator, update negative, zero
// - jump target from both words into pc
// - jump takes two cycles, first idle
// - pointer load twelve-bit literal, two-bit select
// - pointer high byte first, low byte second
`timescale 1ns/1ps
`include "isxe_params.svh"
module isxe_exec (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [7:0]  file_rd_data,
  input  wire logic [3:0]  bank_select_register,
  output logic [11:0]      file_rd_addr,
  output logic             file_wr_en,
  output logic [11:0]      file_wr_addr,
  output logic [7:0]       file_wr_data,
  output logic [7:0]       working_register,
  output logic [4:0]       status_flags,
  output logic [20:1]      pc_target,
  output logic             pc_load,
  output logic             ptr_wr_hi,
  output logic             ptr_wr_lo,
  output logic [1:0]       ptr_sel,
  output logic [7:0]       ptr_data,
  output logic             skip_busy
);
  isxe_pkg::isxe_regs_t cur_ff;
  isxe_pkg::isxe_regs_t nxt_cur;
  logic [11:0]          addr_ff;
  logic [11:0]          nxt_addr;
  logic [8:0]           sum;
  logic [4:0]           nib;
  logic [7:0]           res;
  logic                 is_dsz, is_dsnz, is_isz, is_isnz, is_inc, is_orr;

  // opcode decode from the current word
  assign is_dsz  = instr_word[15:10] == `ISXE_OP6_DEC_SKZ;
  assign is_dsnz = instr_word[15:10] == `ISXE_OP6_DEC_SKNZ;
  assign is_isz  = instr_word[15:10] == `ISXE_OP6_INC_SKZ;
  assign is_isnz = instr_word[15:10] == `ISXE_OP6_INC_SKNZ;
  assign is_inc  = instr_word[15:10] == `ISXE_OP6_INC;
  assign is_orr  = instr_word[15:10] == `ISXE_OP6_OR_REG;

  // file address is decoded combinationally; file_rd_addr shows it one cycle later from addr_ff
  always_comb begin
    if (instr_word[8]) begin
      nxt_addr = {bank_select_register, instr_word[7:0]};
    end else begin
      nxt_addr = {`ISXE_ACCESS_BANK, instr_word[7:0]};
    end
  end

  // one pass per taken word; pulses drop back unless set again, idle cycles freeze the rest
  always_comb begin
    nxt_cur           = cur_ff;
    nxt_cur.wr_en     = 1'b0;
    nxt_cur.pc_load   = 1'b0;
    nxt_cur.ptr_wr_hi = 1'b0;
    nxt_cur.ptr_wr_lo = 1'b0;
    sum = 9'h000;
    nib = 5'h00;
    res = 8'h00;
    if (is_dsz || is_dsnz) begin
      sum = {1'b0, file_rd_data} - 9'h001;
    end else begin
      sum = {1'b0, file_rd_data} + 9'h001;
    end
    nib = {1'b0, file_rd_data[3:0]} + 5'h01;
    if (instr_valid) begin
      case (cur_ff.st)
        isxe_pkg::ISXE_ST_EXEC: begin
          nxt_cur.skip_busy = 1'b0;
          if (is_dsz || is_dsnz || is_isz || is_isnz || is_inc || is_orr) begin
            res = is_orr ? (cur_ff.acc | file_rd_data) : sum[7:0];
            if (instr_word[9]) begin
              nxt_cur.wr_en   = 1'b1;
              nxt_cur.wr_addr = nxt_addr;
              nxt_cur.wr_data = res;
            end else begin
              nxt_cur.acc = res;
            end
            // skips take no flags at all
            if (is_inc) begin
              nxt_cur.flags[`ISXE_FLAG_C]  = sum[8];
              nxt_cur.flags[`ISXE_FLAG_DC] = nib[4];
              nxt_cur.flags[`ISXE_FLAG_OV] = (file_rd_data == 8'h7F);
              nxt_cur.flags[`ISXE_FLAG_N]  = res[7];
              nxt_cur.flags[`ISXE_FLAG_Z]  = (res == 8'h00);
            end else if (is_orr) begin
              nxt_cur.flags[`ISXE_FLAG_N] = res[7];
              nxt_cur.flags[`ISXE_FLAG_Z] = (res == 8'h00);
            end
            if (((is_dsz || is_isz) && res == 8'h00) || ((is_dsnz || is_isnz) && res != 8'h00)) begin
              nxt_cur.st        = isxe_pkg::ISXE_ST_SKIP;
              nxt_cur.skip_busy = 1'b1;
            end
          end else if (instr_word[15:8] == `ISXE_OP8_OR_LIT) begin
            res = cur_ff.acc | instr_word[7:0];
            nxt_cur.acc = res;
            nxt_cur.flags[`ISXE_FLAG_N] = res[7];
            nxt_cur.flags[`ISXE_FLAG_Z] = (res == 8'h00);
          end else if (instr_word[15:8] == `ISXE_OP8_JUMP) begin
            nxt_cur.jump_lo = instr_word[7:0];
            nxt_cur.st      = isxe_pkg::ISXE_ST_JUMP2;
          end else if (instr_word[15:6] == `ISXE_OP10_LDPTR) begin
            nxt_cur.ptr_sel   = instr_word[5:4];
            nxt_cur.ptr_data  = {4'h0, instr_word[3:0]};
            nxt_cur.ptr_wr_hi = 1'b1;
            nxt_cur.st        = isxe_pkg::ISXE_ST_LDPTR2;
          end
        end
        isxe_pkg::ISXE_ST_SKIP: begin
          // skipped word is idle; a two-word one keeps us for its second word
          if (instr_word[15:8] == `ISXE_OP8_JUMP || instr_word[15:6] == `ISXE_OP10_LDPTR) begin
            nxt_cur.st = isxe_pkg::ISXE_ST_SKIP;
            nxt_cur.skip_busy = 1'b1;
          end else begin
            nxt_cur.st = isxe_pkg::ISXE_ST_EXEC;
            nxt_cur.skip_busy = 1'b0;
          end
        end
        isxe_pkg::ISXE_ST_JUMP2: begin
          nxt_cur.pc      = {instr_word[11:0], cur_ff.jump_lo};
          nxt_cur.pc_load = 1'b1;
          nxt_cur.st      = isxe_pkg::ISXE_ST_EXEC;
        end
        isxe_pkg::ISXE_ST_LDPTR2: begin
          nxt_cur.ptr_data  = instr_word[7:0];
          nxt_cur.ptr_wr_lo = 1'b1;
          nxt_cur.st        = isxe_pkg::ISXE_ST_EXEC;
        end
        default: begin
          nxt_cur.st = isxe_pkg::ISXE_ST_EXEC;
        end
      endcase
    end
  end

  // state and address registers; reset loads constants only
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cur_ff  <= '0;
      addr_ff <= 12'h000;
    end else begin
      cur_ff  <= nxt_cur;
      addr_ff <= nxt_addr;
    end
  end

  // outputs straight from the state and address registers, so no decode glitch reaches the neighbours
  assign file_rd_addr     = addr_ff;
  assign file_wr_en       = cur_ff.wr_en;
  assign file_wr_addr     = cur_ff.wr_addr;
  assign file_wr_data     = cur_ff.wr_data;
  assign working_register = cur_ff.acc;
  assign status_flags     = cur_ff.flags;
  assign pc_target        = cur_ff.pc;
  assign pc_load          = cur_ff.pc_load;
  assign ptr_wr_hi        = cur_ff.ptr_wr_hi;
  assign ptr_wr_lo        = cur_ff.ptr_wr_lo;
  assign ptr_sel          = cur_ff.ptr_sel;
  assign ptr_data         = cur_ff.ptr_data;
  assign skip_busy        = cur_ff.skip_busy;

  // named steps of the multi-cycle behaviours; several of the properties below are built from them
  sequence s_skip_cmd;
    instr_valid && cur_ff.st == isxe_pkg::ISXE_ST_EXEC && (is_dsz || is_dsnz || is_isz || is_isnz);
  endsequence
  sequence s_jump_first;
    instr_valid && cur_ff.st == isxe_pkg::ISXE_ST_EXEC && instr_word[15:8] == `ISXE_OP8_JUMP;
  endsequence
  sequence s_ldptr_first;
    instr_valid && cur_ff.st == isxe_pkg::ISXE_ST_EXEC && instr_word[15:6] == `ISXE_OP10_LDPTR;
  endsequence
  sequence s_skip_over_two;
    instr_valid && cur_ff.st == isxe_pkg::ISXE_ST_SKIP &&
      (instr_word[15:8] == `ISXE_OP8_JUMP || instr_word[15:6] == `ISXE_OP10_LDPTR);
  endsequence

  chk_skip_flags_hold: assert property (@(posedge clk_sys) disable iff (reset)
    s_skip_cmd |=> $stable(status_flags)) else $error("skip changed flags");
  // jump: first cycle only latches, the second word loads the target
  chk_jump_first_idle: assert property (@(posedge clk_sys) disable iff (reset)
    s_jump_first |=> !pc_load) else $error("jump loaded pc early");
  chk_jump_two_cyc: assert property (@(posedge clk_sys) disable iff (reset)
    (s_jump_first ##1 instr_valid) |=> pc_load) else $error("jump did not load pc");
  chk_jump_target: assert property (@(posedge clk_sys) disable iff (reset)
    pc_load |-> pc_target[8:1] == $past(cur_ff.jump_lo)) else $error("jump low byte wrong");
  // pointer load: high part on the first word, low byte on the next one
  chk_ptr_hi_first: assert property (@(posedge clk_sys) disable iff (reset)
    s_ldptr_first |=> ptr_wr_hi && !ptr_wr_lo) else $error("pointer high write missing");
  chk_ptr_lit_hi: assert property (@(posedge clk_sys) disable iff (reset)
    s_ldptr_first |=> ptr_data == {4'h0, $past(instr_word[3:0])}) else $error("pointer high part wrong");
  chk_ptr_order: assert property (@(posedge clk_sys) disable iff (reset)
    (s_ldptr_first ##1 instr_valid) |=> ptr_wr_lo && !ptr_wr_hi) else $error("pointer low write missing");
  chk_dest_acc: assert property (@(posedge clk_sys) disable iff (reset)
    (instr_valid && cur_ff.st == isxe_pkg::ISXE_ST_EXEC && is_inc && !instr_word[9]) |=> !file_wr_en)
    else $error("dest 0 wrote file");
  chk_bank_access: assert property (@(posedge clk_sys) disable iff (reset)
    !instr_word[8] |=> file_rd_addr[11:8] == `ISXE_ACCESS_BANK) else $error("access bank not used");
  chk_orlit_zero: assert property (@(posedge clk_sys) disable iff (reset)
    (instr_valid && cur_ff.st == isxe_pkg::ISXE_ST_EXEC && instr_word[15:8] == `ISXE_OP8_OR_LIT)
    |=> status_flags[`ISXE_FLAG_Z] == (working_register == 8'h00)) else $error("or literal zero flag");
  chk_skip_idle: assert property (@(posedge clk_sys) disable iff (reset)
    (instr_valid && cur_ff.st == isxe_pkg::ISXE_ST_SKIP) |=> !file_wr_en && !pc_load && !ptr_wr_hi && !ptr_wr_lo)
    else $error("skipped word ran");
  chk_skip_two_word: assert property (@(posedge clk_sys) disable iff (reset)
    s_skip_over_two |=> skip_busy) else $error("two-word skip ended early");
endmodule : isxe_exec

// >>> verilog/isxe_params.svh
// constants for the increment, decrement, or, jump and pointer-load executor
`ifndef ISXE_PARAMS_SVH
`define ISXE_PARAMS_SVH
`define ISXE_OP6_DEC_SKZ   6'h0B
`define ISXE_OP6_DEC_SKNZ  6'h13
`define ISXE_OP6_INC_SKZ   6'h0F
`define ISXE_OP6_INC_SKNZ  6'h12
`define ISXE_OP6_INC       6'h0A
`define ISXE_OP6_OR_REG    6'h04
`define ISXE_OP8_OR_LIT    8'h09
`define ISXE_OP8_JUMP      8'hEF
`define ISXE_OP10_LDPTR    10'h3B8
`define ISXE_OP4_SECOND    4'hF
`define ISXE_FLAG_C        0
`define ISXE_FLAG_DC       1
`define ISXE_FLAG_Z        2
`define ISXE_FLAG_OV       3
`define ISXE_FLAG_N        4
`define ISXE_ACCESS_BANK   4'h0
`endif

// >>> verilog/isxe_pkg.sv
// types for the executor
package isxe_pkg;
  typedef enum logic [1:0] {
    ISXE_ST_EXEC   = 2'h0,
    ISXE_ST_SKIP   = 2'h1,
    ISXE_ST_JUMP2  = 2'h2,
    ISXE_ST_LDPTR2 = 2'h3
  } isxe_state_t;

  typedef struct packed {
    isxe_state_t st;
    logic [1:0]  ptr_sel;
    logic [7:0]  acc;
    logic [4:0]  flags;
    logic [20:1] pc;
    logic        pc_load;
    logic [7:0]  jump_lo;
    logic        wr_en;
    logic [11:0] wr_addr;
    logic [7:0]  wr_data;
    logic        ptr_wr_hi;
    logic        ptr_wr_lo;
    logic [7:0]  ptr_data;
    logic        skip_busy;
  } isxe_regs_t;
endpackage : isxe_pkg

// >>> sim/tb_top.sv
// self-checking bench for the skip, increment, or, jump and pointer-load executor
`timescale 1ns/1ps
`include "isxe_params.svh"
module tb_top;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0]  bank_select_register = 4'h5;
  logic [7:0]  mem [0:4095];
  logic [7:0]  file_rd_data, file_wr_data, working_register, ptr_data;
  logic [11:0] file_wr_addr, file_rd_addr;
  logic [4:0]  status_flags;
  logic [20:1] pc_target;
  logic [1:0]  ptr_sel;
  logic        file_wr_en, pc_load, ptr_wr_hi, ptr_wr_lo, skip_busy;
  int          failures = 0;
  int          total_checks = 0;

  // 50 MHz core clock
  always #10 clk_sys = ~clk_sys;

  // memory answers in the same cycle; the access bit picks bank select or the shared bank
  assign file_rd_data = mem[instr_word[8] ? {bank_select_register, instr_word[7:0]} : {4'h0, instr_word[7:0]}];

  isxe_exec u_isxe_exec (
    .clk_sys              (clk_sys),
    .reset                (reset),
    .instr_valid          (instr_valid),
    .instr_word           (instr_word),
    .file_rd_data         (file_rd_data),
    .bank_select_register (bank_select_register),
    .file_rd_addr         (file_rd_addr),
    .file_wr_en           (file_wr_en),
    .file_wr_addr         (file_wr_addr),
    .file_wr_data         (file_wr_data),
    .working_register     (working_register),
    .status_flags         (status_flags),
    .pc_target            (pc_target),
    .pc_load              (pc_load),
    .ptr_wr_hi            (ptr_wr_hi),
    .ptr_wr_lo            (ptr_wr_lo),
    .ptr_sel              (ptr_sel),
    .ptr_data             (ptr_data),
    .skip_busy            (skip_busy)
  );

  task automatic conclude;
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one word per cycle, driven just after the edge; results are settled 2 ns past the taking edge
  task automatic send(input logic [15:0] w);
    instr_word = w;
    instr_valid = 1'b1;
    @(posedge clk_sys);
    #2;
  endtask : send

  function automatic logic [15:0] op6(input logic [5:0] o, input logic d, input logic a, input logic [7:0] f);
    return {o, d, a, f};
  endfunction : op6

  // each skip kind once skipping, once not; the word after a skip must not reach the accumulator
  task automatic t_skips;
    logic [5:0] ops [4];
    logic [7:0] vals [4];
    logic [7:0] v, res;
    logic [4:0] fl;
    logic       sk;
    ops = '{`ISXE_OP6_DEC_SKZ, `ISXE_OP6_DEC_SKNZ, `ISXE_OP6_INC_SKZ, `ISXE_OP6_INC_SKNZ};
    vals = '{8'h01, 8'h05, 8'hFF, 8'h10};
    mem[12'h020] = 8'h77;
    mem[12'h030] = 8'h41;
    mem[12'h031] = 8'h0F;
    for (int n = 0; n < 8; n++) begin
      v = (n < 4) ? vals[n % 4] : vals[(n % 4) ^ 1];
      res = (n % 4 < 2) ? v - 8'h01 : v + 8'h01;
      sk = (n % 2 == 0) ? (res == 8'h00) : (res != 8'h00);
      mem[12'h520] = v;
      send(op6(`ISXE_OP6_INC, 1'b0, 1'b0, 8'h31));
      fl = status_flags;
      send(op6(ops[n % 4], 1'b1, 1'b1, 8'h20));
      chk(file_wr_en, 1'b1);
      chk(file_wr_addr, 12'h520);
      chk(file_rd_addr, 12'h520);
      chk(file_wr_data, res);
      chk(skip_busy, sk);
      chk(status_flags, fl);
      send(op6(`ISXE_OP6_INC, 1'b0, 1'b0, 8'h30));
      chk(working_register, sk ? 8'h10 : 8'h42);
      chk(skip_busy, 1'b0);
    end
  endtask : t_skips

  // a skip over a jump or a pointer load discards both of its words, and nothing more
  task automatic t_skip_two_word;
    mem[12'h520] = 8'hFF;
    send(op6(`ISXE_OP6_INC, 1'b0, 1'b0, 8'h31));
    send(op6(`ISXE_OP6_INC_SKZ, 1'b1, 1'b1, 8'h20));
    send({`ISXE_OP8_JUMP, 8'h12});
    chk(skip_busy, 1'b1);
    send({`ISXE_OP4_SECOND, 12'hABC});
    chk(pc_load, 1'b0);
    send(op6(`ISXE_OP6_INC, 1'b0, 1'b0, 8'h30));
    chk(pc_load, 1'b0);
    chk(working_register, 8'h42);
    send(op6(`ISXE_OP6_INC_SKZ, 1'b1, 1'b1, 8'h20));
    send({`ISXE_OP10_LDPTR, 2'h1, 4'h3});
    chk(ptr_wr_hi, 1'b0);
    chk(skip_busy, 1'b1);
    send({8'hF0, 8'h55});
    chk(ptr_wr_lo, 1'b0);
    chk(skip_busy, 1'b0);
  endtask : t_skip_two_word

  // flag corners: 7F gives N, OV, DC; FF wraps to zero with C, DC, Z
  task automatic t_increment;
    mem[12'h040] = 8'h7F;
    mem[12'h540] = 8'h00;
    mem[12'h041] = 8'h00;
    mem[12'h541] = 8'hFF;
    send(op6(`ISXE_OP6_INC, 1'b0, 1'b0, 8'h40));
    chk(working_register, 8'h80);
    chk(status_flags, 5'h1A);
    chk(file_wr_en, 1'b0);
    chk(file_rd_addr, 12'h040);
    send(op6(`ISXE_OP6_INC, 1'b1, 1'b1, 8'h41));
    chk(file_wr_data, 8'h00);
    chk(status_flags, 5'h07);
    chk(working_register, 8'h80);
  endtask : t_increment

  task automatic t_or;
    send({`ISXE_OP8_OR_LIT, 8'h35});
    chk(working_register, 8'hB5);
    chk(status_flags, 5'h13);
    send(op6(`ISXE_OP6_OR_REG, 1'b1, 1'b0, 8'h30));
    chk(file_wr_data, 8'hF5);
    chk(working_register, 8'hB5);
    send(op6(`ISXE_OP6_OR_REG, 1'b0, 1'b0, 8'h31));
    chk(working_register, 8'hBF);
    chk(file_wr_en, 1'b0);
    chk(status_flags, 5'h13);
  endtask : t_or

  // jump then pointer load back to back
  task automatic t_jump_ptr;
    send({`ISXE_OP8_JUMP, 8'h34});
    chk(pc_load, 1'b0);
    send({`ISXE_OP4_SECOND, 12'h9AB});
    chk(pc_load, 1'b1);
    chk(pc_target, 20'h9AB34);
    send({`ISXE_OP10_LDPTR, 2'h2, 4'h7});
    chk(pc_load, 1'b0);
    chk(ptr_wr_hi, 1'b1);
    chk(ptr_data, 8'h07);
    send({8'hF0, 8'hC5});
    chk(ptr_wr_lo, 1'b1);
    chk(ptr_wr_hi, 1'b0);
    chk(ptr_data, 8'hC5);
    chk(ptr_sel, 2'h2);
    instr_valid = 1'b0;
    @(posedge clk_sys);
    #2;
    chk(ptr_wr_lo, 1'b0);
  endtask : t_jump_ptr

  initial begin
    repeat (3) @(posedge clk_sys);
    #2 reset = 1'b0;
    t_skips();
    t_skip_two_word();
    t_increment();
    t_or();
    t_jump_ptr();
    conclude();
  end

  // watchdog: a hung run counts as a mismatch
  initial begin
    repeat (2000) @(posedge clk_sys);
    failures++;
    conclude();
  end
endmodule : tb_top
